// *** design/slb_link_test.sv ***
// Link self test, remote wake-up, pass-through and general I/O forwarding
`timescale 1ns/1ps
`include "slb_cfg.svh"

// Contract
// - Pass-through on forwards bus commands, off withholds
// - Pass-through same in camera and display
// - Four general inputs mirrored to outputs
// - Forwarded inputs skew below 25 us
// - Checking runs while locked and enable high
// - Errors after enable low are ignored
// - Flag high only if all payloads clean
// - Self test only in camera mode
// - Low inputs select test clock source
// - Back-channel command starts serializer test sending; here the self test enable pin starts it, in camera mode while active
// - Serializer sends pseudo-random pattern during test
// - Failing frame pulses flag low per bit; here the first error pulls the flag low until new test or power-down
// - Error counter accumulates detected errors
// - General output 0 shows pass during test
// - Flag holds until new test or power-down
// - Serializer standby until wake-up received
// - Active uses pixel clock else oscillator
// - Clearing wake bit returns serializer to standby
module slb_link_test #(
    parameter int GPIO_WIDTH = 4,
    parameter int ERR_WIDTH = 8,
    parameter int SAMPLE_CYC = `SLB_GPIO_SAMPLE_CYC
) (
    input wire logic clock,
    input wire logic srst,
    // Pins, asynchronous to clock
    input wire logic self_test_enable_pin,
    input wire logic link_locked_pin,
    input wire logic power_down_input_n,
    input wire logic camera_mode_pin,
    input wire logic pixel_clock_present,
    input wire logic [GPIO_WIDTH-1:0] general_input,
    // Register port
    input wire logic reg_wr,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    // Bus command pass-through
    input wire logic bus_cmd_valid,
    input wire logic [7:0] bus_cmd_data,
    output logic remote_cmd_valid,
    output logic [7:0] remote_cmd_data,
    // Received payload checking, same clock
    input wire logic rx_valid,
    input wire logic rx_bit,
    // Serializer side outputs
    output logic [GPIO_WIDTH-1:0] general_output,
    output logic tx_bit,
    output logic [1:0] test_clk_sel,
    output logic use_oscillator,
    output logic [1:0] ser_state,
    output logic pass_flag,
    output logic [ERR_WIDTH-1:0] err_count
);

    // Pin synchronisers, two stages each
    localparam int NSYNC = GPIO_WIDTH + 5;
    logic [NSYNC-1:0] sync1_ff, sync2_ff;
    logic [NSYNC-1:0] nxt_sync1, nxt_sync2;
    logic s_link_self_test, s_lock, s_pdn_n, s_cam, s_pclk;
    logic [GPIO_WIDTH-1:0] s_gpi;

    // Sync combinational stage
    always_comb begin
        nxt_sync1 = {general_input, pixel_clock_present, camera_mode_pin,
            power_down_input_n, link_locked_pin, self_test_enable_pin};
        nxt_sync2 = sync1_ff;
    end

    // Sync registers
    always_ff @(posedge clock) begin
        if (srst) begin
            // Power-down bit rests high, as its pin idles, so no false edge
            sync1_ff <= {{(NSYNC-3){1'b0}}, 3'h4};
            sync2_ff <= {{(NSYNC-3){1'b0}}, 3'h4};
        end else begin
            sync1_ff <= nxt_sync1;
            sync2_ff <= nxt_sync2;
        end
    end

    // Names for the synchronised pins
    assign s_link_self_test = sync2_ff[0];
    assign s_lock = sync2_ff[1];
    assign s_pdn_n = sync2_ff[2];
    assign s_cam = sync2_ff[3];
    assign s_pclk = sync2_ff[4];
    assign s_gpi = sync2_ff[NSYNC-1:5];

    // Register file state
    logic [7:0] gen_cfg_ff, nxt_gen_cfg;
    logic [7:0] bc_wake_ff, nxt_bc_wake;
    logic [7:0] bc_norm_ff, nxt_bc_norm;
    logic [7:0] rdata_ff, nxt_rdata;
    logic [ERR_WIDTH-1:0] err_cnt_ff, nxt_err_cnt; // Error counter, also read back

    // Register writes and read mux
    always_comb begin
        nxt_gen_cfg = gen_cfg_ff;
        nxt_bc_wake = bc_wake_ff;
        nxt_bc_norm = bc_norm_ff;
        if (reg_wr) begin
            case (reg_addr)
                `SLB_OFF_GENERAL_CONFIG: nxt_gen_cfg = reg_wdata;
                `SLB_OFF_BC_WAKE_CONFIG: nxt_bc_wake = reg_wdata;
                `SLB_OFF_BC_NORMAL_CONFIG: nxt_bc_norm = reg_wdata;
                default: nxt_gen_cfg = gen_cfg_ff;
            endcase
        end
        case (reg_addr)
            `SLB_OFF_GENERAL_CONFIG: nxt_rdata = gen_cfg_ff;
            `SLB_OFF_BC_WAKE_CONFIG: nxt_rdata = bc_wake_ff;
            `SLB_OFF_BC_NORMAL_CONFIG: nxt_rdata = bc_norm_ff;
            `SLB_OFF_ERR_COUNT: nxt_rdata = 8'(err_cnt_ff);
            default: nxt_rdata = 8'h00;
        endcase
    end

    // Register file flops
    always_ff @(posedge clock) begin
        if (srst) begin
            gen_cfg_ff <= `SLB_RST_GENERAL_CONFIG;
            bc_wake_ff <= `SLB_RST_BC_CONFIG;
            bc_norm_ff <= `SLB_RST_BC_CONFIG;
            rdata_ff <= 8'h00;
        end else begin
            gen_cfg_ff <= nxt_gen_cfg;
            bc_wake_ff <= nxt_bc_wake;
            bc_norm_ff <= nxt_bc_norm;
            rdata_ff <= nxt_rdata;
        end
    end

    // Serializer state, pattern generator, checker and result
    slb_pkg::slb_ser_state_type st_ff, nxt_st;
    logic [15:0] prbs_tx_ff, nxt_prbs_tx;
    logic [15:0] prbs_rx_ff, nxt_prbs_rx;
    logic pass_ff, nxt_pass;
    logic fail_half_ff, nxt_fail_half;
    logic pdn_n_d_ff;
    logic link_self_test_d_ff;
    logic test_run;
    logic rx_err;

    // Checking window: locked, enabled, camera mode only
    assign test_run = s_link_self_test && s_lock && s_cam;
    assign rx_err = rx_valid && (rx_bit != prbs_rx_ff[15]);

    // Next state for the test and wake logic
    always_comb begin
        nxt_st = st_ff;
        nxt_prbs_tx = prbs_tx_ff;
        nxt_prbs_rx = prbs_rx_ff;
        nxt_pass = pass_ff;
        nxt_fail_half = 1'b0;
        nxt_err_cnt = err_cnt_ff;
        case (st_ff)
            slb_pkg::SLB_STANDBY: begin
                // Wake only in camera mode and with the remote wake bit set
                if (gen_cfg_ff[`SLB_BIT_REMOTE_WAKE] && s_cam) begin
                    nxt_st = slb_pkg::SLB_ACTIVE;
                end
            end
            slb_pkg::SLB_ACTIVE: begin
                if (!gen_cfg_ff[`SLB_BIT_REMOTE_WAKE]) begin
                    nxt_st = slb_pkg::SLB_STANDBY;
                end else if (s_link_self_test && s_cam) begin
                    nxt_st = slb_pkg::SLB_SELF_TEST;
                    nxt_prbs_tx = `SLB_PRBS_SEED;
                end
            end
            slb_pkg::SLB_SELF_TEST: begin
                // Free-running pattern toward the deserializer
                nxt_prbs_tx = {prbs_tx_ff[14:0], prbs_tx_ff[15] ^ prbs_tx_ff[13]
                    ^ prbs_tx_ff[12] ^ prbs_tx_ff[10]};
                if (!gen_cfg_ff[`SLB_BIT_REMOTE_WAKE]) begin
                    nxt_st = slb_pkg::SLB_STANDBY;
                end else if (!s_link_self_test || !s_cam) begin
                    nxt_st = slb_pkg::SLB_ACTIVE;
                end
            end
            default: nxt_st = slb_pkg::SLB_STANDBY;
        endcase
        // Power-down toggle restores a passing result; a same-cycle error wins
        if (s_pdn_n && !pdn_n_d_ff) begin
            nxt_pass = 1'b1;
        end
        // New session clears result and counter
        if (s_link_self_test && !link_self_test_d_ff) begin
            nxt_pass = 1'b1;
            nxt_err_cnt = '0;
            nxt_prbs_rx = `SLB_PRBS_SEED;
        end else if (test_run && rx_valid) begin
            nxt_prbs_rx = {prbs_rx_ff[14:0], prbs_rx_ff[15] ^ prbs_rx_ff[13]
                ^ prbs_rx_ff[12] ^ prbs_rx_ff[10]};
            if (rx_err) begin
                nxt_pass = 1'b0;
                nxt_fail_half = 1'b1;
                if (err_cnt_ff != '1) begin
                    nxt_err_cnt = err_cnt_ff + 1'b1;
                end
            end
        end
    end

    // Registers for the test and wake logic
    always_ff @(posedge clock) begin
        if (srst) begin
            st_ff <= slb_pkg::SLB_STANDBY;
            prbs_tx_ff <= `SLB_PRBS_SEED;
            prbs_rx_ff <= `SLB_PRBS_SEED;
            pass_ff <= 1'b1;
            fail_half_ff <= 1'b0;
            err_cnt_ff <= '0;
            pdn_n_d_ff <= 1'b1; // Idle level of the power-down pin
            link_self_test_d_ff <= 1'b0;
        end else begin
            st_ff <= nxt_st;
            prbs_tx_ff <= nxt_prbs_tx;
            prbs_rx_ff <= nxt_prbs_rx;
            pass_ff <= nxt_pass;
            fail_half_ff <= nxt_fail_half;
            err_cnt_ff <= nxt_err_cnt;
            pdn_n_d_ff <= s_pdn_n;
            link_self_test_d_ff <= s_link_self_test;
        end
    end

    // General I/O sampler: periodic snapshot bounds latency and skew
    logic [$clog2(SAMPLE_CYC+1)-1:0] samp_cnt_ff, nxt_samp_cnt;
    logic [GPIO_WIDTH-1:0] gpo_ff, nxt_gpo;
    logic cmd_v_ff, nxt_cmd_v;
    logic [7:0] cmd_d_ff, nxt_cmd_d;

    // Forwarding next values
    always_comb begin
        nxt_samp_cnt = samp_cnt_ff + 1'b1;
        nxt_gpo = gpo_ff;
        if (samp_cnt_ff >= ($clog2(SAMPLE_CYC+1))'(SAMPLE_CYC - 1)) begin
            nxt_samp_cnt = '0;
            nxt_gpo = s_gpi;
        end
        // Pass flag on output 0 while testing
        if (st_ff == slb_pkg::SLB_SELF_TEST) begin
            nxt_gpo[0] = pass_ff;
        end
        // Mode pin plays no part: same in both configurations
        nxt_cmd_v = bus_cmd_valid && gen_cfg_ff[`SLB_BIT_PASSTHRU];
        nxt_cmd_d = nxt_cmd_v ? bus_cmd_data : 8'h00;
    end

    // Forwarding registers
    always_ff @(posedge clock) begin
        if (srst) begin
            samp_cnt_ff <= '0;
            gpo_ff <= '0;
            cmd_v_ff <= 1'b0;
            cmd_d_ff <= 8'h00;
        end else begin
            samp_cnt_ff <= nxt_samp_cnt;
            gpo_ff <= nxt_gpo;
            cmd_v_ff <= nxt_cmd_v;
            cmd_d_ff <= nxt_cmd_d;
        end
    end

    // Output registers
    logic [1:0] clk_sel_ff;
    logic osc_ff;
    logic tx_ff;
    logic pass_out_ff;

    // Clock choice and serial bit, registered
    always_ff @(posedge clock) begin
        if (srst) begin
            clk_sel_ff <= 2'h0;
            osc_ff <= 1'b1;
            tx_ff <= 1'b0;
            pass_out_ff <= 1'b1;
        end else begin
            // Test clock from the two low inputs; 00 means external
            clk_sel_ff <= s_gpi[1:0];
            if (st_ff == slb_pkg::SLB_SELF_TEST) begin
                osc_ff <= (s_gpi[1:0] != slb_pkg::SLB_CLK_EXT);
            end else begin
                osc_ff <= !s_pclk;
            end
            tx_ff <= (st_ff == slb_pkg::SLB_SELF_TEST) ? prbs_tx_ff[15] : 1'b0;
            // Low for one cycle per error, else the held result
            pass_out_ff <= nxt_fail_half ? 1'b0 : nxt_pass;
        end
    end

    assign reg_rdata = rdata_ff;
    assign remote_cmd_valid = cmd_v_ff;
    assign remote_cmd_data = cmd_d_ff;
    assign general_output = gpo_ff;
    assign tx_bit = tx_ff;
    assign test_clk_sel = clk_sel_ff;
    assign use_oscillator = osc_ff;
    assign ser_state = st_ff;
    assign pass_flag = pass_out_ff;
    assign err_count = err_cnt_ff;

endmodule : slb_link_test

// *** dv/slb_far_model.sv ***
// Far-side serializer stand-in streaming test bits into the checker
`timescale 1ns/1ps
`include "slb_cfg.svh"
module slb_far_model (
    input wire logic clock,
    input wire logic srst,
    input wire logic start,
    input wire logic send,
    input wire logic flip,
    output logic rx_valid,
    output logic rx_bit
);
    logic [15:0] lfsr_ff; // Pattern state
    // One pattern bit per cycle while sending, flip injects an error
    always_ff @(posedge clock) begin
        if (srst || start) begin
            lfsr_ff <= `SLB_PRBS_SEED;
            rx_valid <= 1'b0;
            rx_bit <= 1'b0;
        end else if (send) begin
            lfsr_ff <= {lfsr_ff[14:0], lfsr_ff[15] ^ lfsr_ff[13] ^ lfsr_ff[12] ^ lfsr_ff[10]};
            rx_valid <= 1'b1;
            rx_bit <= lfsr_ff[15] ^ flip;
        end else begin
            // Idle line keeps moving so a stale bit is never trusted
            rx_valid <= 1'b0;
            rx_bit <= ~rx_bit;
        end
    end
endmodule : slb_far_model

// *** dv/slb_link_test_props.sv ***
// Port assertions for the link self test block
`timescale 1ns/1ps
module slb_link_test_props #(
    parameter int GPIO_WIDTH = 4,
    parameter int ERR_WIDTH = 8
) (
    input wire logic clock,
    input wire logic srst,
    input wire logic camera_mode_pin,
    input wire logic pixel_clock_present,
    input wire logic [GPIO_WIDTH-1:0] general_input,
    input wire logic bus_cmd_valid,
    input wire logic [7:0] bus_cmd_data,
    input wire logic remote_cmd_valid,
    input wire logic [7:0] remote_cmd_data,
    input wire logic rx_valid,
    input wire logic tx_bit,
    input wire logic [1:0] test_clk_sel,
    input wire logic use_oscillator,
    input wire logic [1:0] ser_state,
    input wire logic pass_flag,
    input wire logic [ERR_WIDTH-1:0] err_count
);
    default clocking @(posedge clock);
    endclocking
    default disable iff (srst);
    chk_cmd_forward: assert property (
        remote_cmd_valid |-> $past(bus_cmd_valid) && remote_cmd_data == $past(bus_cmd_data))
        else $error("Remote command without a source byte");
    chk_count_step: assert property (
        err_count > $past(err_count) |-> $past(rx_valid) && err_count == $past(err_count) + 1)
        else $error("Error count moved without one received bit");
    chk_flag_cause: assert property (
        $fell(pass_flag) |-> $past(rx_valid))
        else $error("Pass flag fell without a received bit");
    chk_flag_with_count: assert property (
        err_count > $past(err_count) |-> !pass_flag)
        else $error("Counted error left pass flag high");
    chk_display_no_test: assert property (
        !camera_mode_pin [*5] |-> ser_state != 2'h2)
        else $error("Self test running in display mode");
    chk_tx_quiet: assert property (
        (ser_state != 2'h2) [*2] |-> !tx_bit)
        else $error("Pattern sent outside self test");
    chk_sel_follow: assert property (
        $stable(general_input[1:0]) [*5] |-> test_clk_sel == general_input[1:0])
        else $error("Test clock select does not follow inputs");
    chk_osc_choice: assert property (
        (ser_state != 2'h2 && $stable(pixel_clock_present)) [*5]
        |-> use_oscillator == !pixel_clock_present)
        else $error("Clock source wrong outside self test");
    chk_osc_test: assert property (
        (ser_state == 2'h2 && $stable(test_clk_sel)) [*3]
        |-> use_oscillator == (test_clk_sel != 2'h0))
        else $error("Clock source wrong during self test");
endmodule : slb_link_test_props
bind slb_link_test slb_link_test_props #(.GPIO_WIDTH(GPIO_WIDTH), .ERR_WIDTH(ERR_WIDTH)) u_props (
    .clock(clock), .srst(srst), .camera_mode_pin(camera_mode_pin),
    .pixel_clock_present(pixel_clock_present), .general_input(general_input),
    .bus_cmd_valid(bus_cmd_valid), .bus_cmd_data(bus_cmd_data),
    .remote_cmd_valid(remote_cmd_valid), .remote_cmd_data(remote_cmd_data),
    .rx_valid(rx_valid), .tx_bit(tx_bit), .test_clk_sel(test_clk_sel),
    .use_oscillator(use_oscillator), .ser_state(ser_state), .pass_flag(pass_flag),
    .err_count(err_count));

// *** dv/slb_link_test_test.sv ***
// Self-checking bench for the link self test block
`timescale 1ns/1ps
`include "slb_cfg.svh"
module slb_link_test_test;
    logic clock = 0, srst = 1, st_en = 0, lock = 0, pd_n = 1, cam = 0, pcp = 0; // Pins
    logic wr_en = 0, bus_v = 0, start = 0, send = 0, flip = 0; // Strobes
    logic [3:0] gi = 4'h0, gout; // General I/O
    logic [7:0] addr = 8'h00, wdata = 8'h00, bus_d = 8'h00, rdata, rem_d, cnt; // Bytes
    logic rem_v, rx_v, rx_b, tx_b, osc, pass; // Single outputs
    logic [1:0] sel, state; // Two-bit outputs
    int miscompares = 0, checks = 0, seed = 32'hFAA9E08D, exp_cnt, exp_pass; // Model
    // Free-running clock
    initial forever #2 clock = ~clock;
    slb_link_test #(.SAMPLE_CYC(4)) u_dut (.clock(clock), .srst(srst),
        .self_test_enable_pin(st_en), .link_locked_pin(lock), .power_down_input_n(pd_n),
        .camera_mode_pin(cam), .pixel_clock_present(pcp), .general_input(gi),
        .reg_wr(wr_en), .reg_addr(addr), .reg_wdata(wdata), .reg_rdata(rdata),
        .bus_cmd_valid(bus_v), .bus_cmd_data(bus_d), .remote_cmd_valid(rem_v),
        .remote_cmd_data(rem_d), .rx_valid(rx_v), .rx_bit(rx_b), .general_output(gout),
        .tx_bit(tx_b), .test_clk_sel(sel), .use_oscillator(osc), .ser_state(state),
        .pass_flag(pass), .err_count(cnt));
    slb_far_model u_far (.clock(clock), .srst(srst), .start(start), .send(send),
        .flip(flip), .rx_valid(rx_v), .rx_bit(rx_b));
    // Compare one result
    task automatic cmp(input string what, input logic [7:0] exp, input logic [7:0] got);
        checks++;
        if (got !== exp) begin
            miscompares++;
            $display("unexpected %s: expected %h seen %h", what, exp, got);
        end
    endtask : cmp
    task automatic tick(input int n);
        repeat (n) @(negedge clock);
    endtask : tick
    // Register write, one strobe cycle
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        addr = a;
        wdata = d;
        wr_en = 1;
        tick(1);
        wr_en = 0;
        // One idle edge so a following write never re-raises the strobe at once
        tick(1);
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string what);
        addr = a;
        tick(2);
        cmp(what, exp, rdata);
    endtask : rd
    // One self test run with the given clock code
    task automatic self_test(input logic [1:0] code);
        logic [15:0] lf; // Expected serial pattern
        gi[1:0] = code;
        // Code 00 bypasses the oscillator, so the pixel clock must run
        if (code == 2'h0)
            pcp = 1;
        exp_cnt = 0;
        exp_pass = 1;
        st_en = 1;
        tick(5);
        cmp("clock select", {6'h0, code}, {6'h0, sel});
        cmp("oscillator", {7'h0, code != 2'h0}, {7'h0, osc});
        cmp("serializer state", 8'h02, {6'h0, state});
        // Serial pattern from the seed, one bit per cycle
        lf = `SLB_PRBS_SEED;
        for (int j = 0; j < 8; j++) begin
            lf = {lf[14:0], lf[15] ^ lf[13] ^ lf[12] ^ lf[10]};
            cmp("serial bit", {7'h0, lf[15]}, {7'h0, tx_b});
            tick(1);
        end
        start = 1;
        tick(1);
        start = 0;
        send = 1;
        for (int i = 0; i < 16; i++) begin
            flip = code != 2'h0 && (i == 5 || ($random(seed) & 3) == 0);
            exp_cnt += flip;
            exp_pass = exp_pass & !flip;
            tick(1);
        end
        send = 0;
        flip = 0;
        tick(6);
        cmp("error count", 8'(exp_cnt), cnt);
        cmp("pass flag", 8'(exp_pass), {7'h0, pass});
        cmp("pass output", 8'(exp_pass), {7'h0, gout[0]});
        st_en = 0;
        tick(5);
        send = 1;
        flip = 1;
        tick(2);
        send = 0;
        flip = 0;
        tick(3);
        cmp("late error count", 8'(exp_cnt), cnt);
        cmp("late pass flag", 8'(exp_pass), {7'h0, pass});
        $display("self test code %0d done", code);
    endtask : self_test
    task automatic results;
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : results
    // Watchdog against a hang
    initial begin
        repeat (5000) @(posedge clock);
        miscompares++;
        results();
    end
    // Main sequence
    initial begin
        tick(2);
        srst = 0;
        rd(8'h01, 8'h08, "general config");
        rd(8'h26, 8'h00, "wake driver config");
        rd(8'h28, 8'h00, "error count reg");
        wr(8'h55, 8'hA5);
        rd(8'h55, 8'h00, "unmapped");
        $display("register test done");
        lock = 1;
        for (int m = 0; m < 2; m++) begin
            for (int e = 0; e < 2; e++) begin
                cam = m[0];
                wr(8'h01, e[0] ? 8'h08 : 8'h00);
                bus_d = 8'($random(seed));
                bus_v = 1;
                tick(1);
                bus_v = 0;
                cmp("remote valid", 8'(e), {7'h0, rem_v});
                if (e[0])
                    cmp("remote data", bus_d, rem_d);
            end
        end
        $display("pass-through test done");
        cam = 0;
        gi = 4'($random(seed));
        for (int i = 0; i < 40 && gout !== gi; i++)
            tick(1);
        cmp("general output", {4'h0, gi}, {4'h0, gout});
        $display("general io test done");
        wr(8'h01, 8'h0C);
        tick(4);
        cmp("display wake", 8'h00, {6'h0, state});
        wr(8'h01, 8'h08);
        cam = 1;
        wr(8'h26, 8'hC0);
        cmp("standby before wake", 8'h00, {6'h0, state});
        wr(8'h01, 8'h0C);
        wr(8'h26, 8'h00);
        wr(8'h27, 8'hC0);
        tick(4);
        cmp("woken state", 8'h01, {6'h0, state});
        rd(8'h27, 8'hC0, "normal driver config");
        pcp = 1'($random(seed));
        tick(5);
        cmp("active clock source", {7'h0, !pcp}, {7'h0, osc});
        for (int c = 0; c < 4; c++)
            self_test(2'(c));
        pd_n = 0;
        tick(3);
        pd_n = 1;
        tick(5);
        cmp("pass after power-down", 8'h01, {7'h0, pass});
        wr(8'h01, 8'h08);
        tick(4);
        cmp("standby state", 8'h00, {6'h0, state});
        $display("wake and power test done");
        results();
    end
endmodule : slb_link_test_test

// *** pkg/slb_cfg.svh ***
// Constants for the link self test and wake-up block
`ifndef SLB_CFG_SVH
`define SLB_CFG_SVH
// Register offsets on the register port
`define SLB_OFF_GENERAL_CONFIG 8'h01
`define SLB_OFF_BC_WAKE_CONFIG 8'h26
`define SLB_OFF_BC_NORMAL_CONFIG 8'h27
`define SLB_OFF_ERR_COUNT 8'h28
// Field positions
`define SLB_BIT_REMOTE_WAKE 2
`define SLB_BIT_PASSTHRU 3
// Reset values
`define SLB_RST_GENERAL_CONFIG 8'h08
`define SLB_RST_BC_CONFIG 8'h00
// Pattern generator seed
`define SLB_PRBS_SEED 16'hACE1
// Timing
`define SLB_CLK_MHZ 250
`define SLB_GPIO_RATE_KHZ 66
`define SLB_GPIO_SKEW_US 25
// Fastest sampling interval keeps well under the skew budget
`define SLB_GPIO_SAMPLE_CYC ((`SLB_CLK_MHZ * 1000) / (`SLB_GPIO_RATE_KHZ * 4))
`define SLB_GPIO_SKEW_CYC (`SLB_GPIO_SKEW_US * `SLB_CLK_MHZ)
`endif

// *** pkg/slb_pkg.sv ***
// Types for the link self test and wake-up block
package slb_pkg;
    // Test clock choice from the two low general inputs
    typedef enum logic [1:0] {
        SLB_CLK_EXT = 2'h0,
        SLB_CLK_50 = 2'h1,
        SLB_CLK_25 = 2'h2,
        SLB_CLK_12P5 = 2'h3
    } slb_clk_sel_type;
    // Serializer power state
    typedef enum logic [1:0] {
        SLB_STANDBY,
        SLB_ACTIVE,
        SLB_SELF_TEST
    } slb_ser_state_type;
endpackage : slb_pkg
